// ---- rtl/pmcs_pkg.sv ----
// constants, field layouts and carrier types for the power mode and clock select block
package pmcs_pkg;

  // clocking: 25 MHz reference multiplied up to the 50 MHz logic clock
  localparam int REF_CLK_MHZ = 25;
  localparam int PLL_MULT = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RMII_REF_MHZ = 50;
  localparam int SYNC_CLK_LOW_MHZ = 25;
  localparam int SYNC_CLK_HIGH_MHZ = 125;

  // energy must be present for longer than this before leaving low power
  localparam int ENERGY_PRESENT_NS = 100;
  localparam int ENERGY_PRESENT_CYC = (ENERGY_PRESENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENERGY_EXIT_CYC = ENERGY_PRESENT_CYC + 1;
  localparam logic [2:0] ENERGY_EXIT_LAST = 3'(ENERGY_EXIT_CYC - 1);

  // power down control byte, mode field at [4:3]
  localparam int CTRL_WIDTH = 8;
  localparam int PWR_MODE_LSB = 3;
  localparam int PWR_MODE_MSB = 4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY_DETECT_POWER_DOWN = 2'h1;
  localparam logic [1:0] MODE_SOFT = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_NORMAL;

  // ports
  localparam int NUM_PORTS = 7;
  localparam int NUM_PHY_PORTS = 5;
  localparam int NUM_MAC_PORTS = 2;
  localparam logic [NUM_PHY_PORTS-1:0] PHY_ALL_ON = 5'h1f;

  // mac interface kinds and speeds
  localparam logic [1:0] IF_MII = 2'h0;
  localparam logic [1:0] IF_RMII = 2'h1;
  localparam logic [1:0] IF_RGMII = 2'h2;
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // sync ethernet clock source: 0 is the reference, 1..5 a phy recovered clock
  localparam logic [2:0] SYNC_SRC_REF = 3'h0;
  localparam logic [2:0] SYNC_SRC_FIRST = 3'h1;
  localparam logic [2:0] SYNC_SRC_LAST = 3'h5;

  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam int TIMEOUT_W = 16;

  typedef struct packed {
    logic [1:0] if_kind;
    logic role;
  } pmcs_strap_type;

  typedef struct packed {
    logic rx_clk_oe_n;
    logic tx_clk_oe_n;
    logic ref_in_sel;
    logic ref_out_oe_n;
    logic [1:0] speed;
  } pmcs_mac_clk_type;

  typedef struct packed {
    logic pll_en;
    logic phy_en;
    logic energy_det_en;
    logic mac_en;
    logic host_if_en;
    logic mgmt_if_en;
  } pmcs_gate_type;

  localparam pmcs_gate_type GATE_ALL_ON = 6'h3f;
  // idle drives no clock pin at all, the rmii reference output included
  localparam pmcs_mac_clk_type MAC_CLK_IDLE = 6'h3d;
  localparam int SYNC_W = NUM_PHY_PORTS + NUM_MAC_PORTS * 3;

endpackage

// ---- rtl/pmcs_sync.sv ----
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module pmcs_sync (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // level
  input wire logic d_in,
  output logic q_out
);
  logic meta;

  // meta is read by q_out only
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meta <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pmcs_energy_detect_power_down.sv ----
// energy-detect normal/low power state machine with link pulse generator
`timescale 1ns/100ps
`default_nettype none
module pmcs_energy_detect_power_down
  import pmcs_pkg::*;
#(
  parameter int PULSE_INTERVAL_CYC = 800000
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic active_in,
  input wire logic energy_in,
  input wire logic [TIMEOUT_W-1:0] timeout_in,
  // state
  output logic low_power_out,
  output logic link_pulse_out
);
  typedef enum logic {ED_NORMAL, ED_LOW} pmcs_ed_state_type;
  localparam logic [31:0] PULSE_LAST = 32'(PULSE_INTERVAL_CYC - 1);

  pmcs_ed_state_type state;
  pmcs_ed_state_type next_state;
  logic [TIMEOUT_W:0] idle_cnt;
  logic [2:0] energy_cnt;
  logic [31:0] pulse_cnt;
  logic quiet_done;
  logic energy_done;

  // wider idle counter so a timeout of all ones can still expire
  assign quiet_done = idle_cnt > {1'b0, timeout_in};
  assign energy_done = energy_in && (energy_cnt == ENERGY_EXIT_LAST);
  assign low_power_out = (state == ED_LOW);

  always_comb begin
    next_state = state;
    case (state)
      ED_NORMAL: begin
        if (active_in && !energy_in && quiet_done) begin
          next_state = ED_LOW; // R16
        end
      end
      ED_LOW: begin
        if (!active_in || energy_done) begin
          next_state = ED_NORMAL; // R19
        end
      end
      default: next_state = ED_NORMAL;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state <= ED_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // quiet time while watching the cable
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !active_in || state != ED_NORMAL || energy_in) begin
      idle_cnt <= '0; // R16
    end else if (!(&idle_cnt)) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // any gap in energy restarts the presence count
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || state != ED_LOW || !energy_in) begin
      energy_cnt <= 3'h0; // R17
    end else begin
      energy_cnt <= energy_cnt + 3'h1; // R19
    end
  end

  // one cycle pulse per interval gives the very low duty cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || state != ED_LOW || pulse_cnt == PULSE_LAST) begin
      pulse_cnt <= 32'h0;
    end else begin
      pulse_cnt <= pulse_cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      link_pulse_out <= 1'b0;
    end else begin
      link_pulse_out <= (state == ED_LOW) && (next_state == ED_LOW) && (pulse_cnt == PULSE_LAST); // R18
    end
  end

  exit_after_energy_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R19
    (low_power_out && active_in && energy_in)[*6] |=> !low_power_out)
    else $error("low power not left after sustained energy");

  short_burst_kept_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R19
    (low_power_out && active_in && !energy_in) ##1 (low_power_out && active_in && energy_in)[*5]
    ##1 (active_in && !energy_in) |=> low_power_out)
    else $error("low power left on energy burst of 100 ns or less");

  enter_on_quiet_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R16
    $rose(low_power_out) |-> $past(active_in) && !$past(energy_in) && ($past(idle_cnt) > {1'b0, $past(timeout_in)}))
    else $error("low power entered without quiet timeout");

  pulse_in_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R18
    link_pulse_out |-> $past(low_power_out) && !$past(link_pulse_out))
    else $error("link pulse outside low power or too wide");
endmodule
`default_nettype wire

// ---- rtl/pmcs_top.sv ----
// power mode sequencing, block gating and interface clock selection
//
// Overview of operation
// R01 - 25 MHz reference multiplied internally clocks all logic; pll enable gates it.
// R02 - MII strap: PHY role drives both clocks, MAC role takes both as inputs.
// R03 - RMII 50 MHz clock: normal mode takes it in, clock mode drives it out.
// R04 - RGMII drives receive clock, takes transmit clock; no role strap needed.
// R05 - RGMII strap picks 100 or 1000; a control bit forces 10.
// R06 - management clock is always an input; device never drives it.
// R07 - sync clock source is the reference, or a selected PHY recovered clock.
// R08 - sync clock is 25 MHz by default or 125 MHz, and can be disabled.
// R09 - after power-up the mode is normal with every block enabled.
// R10 - writing 00 to mode field bits 4:3 selects normal mode.
// R11 - writing 01 to the mode field selects energy-detect mode.
// R12 - exactly one global mode holds at a time, for all ports.
// R13 - host may move from normal mode to any other mode.
// R14 - gate PLL, PHYs, MACs, host interface per mode as tabulated.
// R15 - host keeps auto-negotiation enabled while in energy-detect mode.
// R16 - in energy-detect mode enter low power after quiet beyond timeout.
// R17 - low power disables everything but the receive energy detector; the management interface is also kept enabled here.
// R18 - low power sends sparse link pulses with very low duty cycle.
// R19 - leave low power once energy persists longer than 100 ns.
// R20 - soft power down keeps only the serial management interface alive.
// R21 - leaving soft power down resets registers and resamples straps.
// R22 - each port powers down on its own, alongside any global mode.
// R23 - EEE active only if locally enabled and negotiated; PHY ports only.
// R24 - soft power down uses its own field code, not 00 or 01.
`timescale 1ns/100ps
`default_nettype none
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int PULSE_INTERVAL_CYC = 800000
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // power down control write
  input wire logic mode_wr_in,
  input wire logic [CTRL_WIDTH-1:0] mode_wdata_in,
  input wire logic [TIMEOUT_W-1:0] energy_detect_power_down_timeout_in,
  input wire logic [NUM_PORTS-1:0] port_pd_in,
  // eee qualifiers
  input wire logic [NUM_PHY_PORTS-1:0] eee_local_en_in,
  input wire logic [NUM_PHY_PORTS-1:0] eee_an_ok_in,
  // pins: cable energy and mac port straps
  input wire logic [NUM_PHY_PORTS-1:0] energy_in,
  input wire pmcs_strap_type [NUM_MAC_PORTS-1:0] strap_in,
  input wire logic [NUM_MAC_PORTS-1:0] rgmii_force_10_in,
  // sync ethernet clock control
  input wire logic [2:0] sync_src_in,
  input wire logic sync_freq_125_in,
  input wire logic sync_disable_in,
  // mode and power state
  output logic [1:0] mode_out,
  output logic energy_detect_power_down_low_out,
  output logic link_pulse_out,
  output logic soft_reset_out,
  output logic strap_capture_out,
  // block gating
  output pmcs_gate_type gate_out,
  output logic [NUM_PHY_PORTS-1:0] phy_en_out,
  output logic [NUM_PHY_PORTS-1:0] eee_active_out,
  // interface clocks
  output pmcs_mac_clk_type [NUM_MAC_PORTS-1:0] mac_clk_out,
  output logic mgmt_clk_oe_n_out,
  output logic [2:0] sync_src_out,
  output logic sync_freq_125_out,
  output logic sync_clk_en_out
);
  logic [1:0] mode;
  logic [1:0] wr_field;
  logic wr_valid;
  logic [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] sync_pins;
  logic [NUM_PHY_PORTS-1:0] energy_sync;
  pmcs_strap_type [NUM_MAC_PORTS-1:0] strap_sync;
  pmcs_strap_type [NUM_MAC_PORTS-1:0] strap_latched;
  logic [1:0] settle_cnt;
  logic ed_low;
  logic ed_pulse;
  pmcs_gate_type next_gate;
  logic [NUM_PHY_PORTS-1:0] next_phy_en;
  logic [2:0] next_sync_src;

  function automatic pmcs_gate_type gate_for(input logic [1:0] m, input logic low);
    pmcs_gate_type g;
    g = GATE_ALL_ON;
    if (m == MODE_SOFT) begin
      g = '0;
      g.mgmt_if_en = 1'b1; // R20
    end else if (m == MODE_ENERGY_DETECT_POWER_DOWN && low) begin
      g = '0;
      g.energy_det_en = 1'b1; // R17
      g.mgmt_if_en = 1'b1;
    end
    return g;
  endfunction

  function automatic pmcs_mac_clk_type mac_clk_for(input pmcs_strap_type s, input logic force10,
                                                   input logic en);
    pmcs_mac_clk_type c;
    c = MAC_CLK_IDLE;
    if (en) begin
      case (s.if_kind)
        IF_MII: begin
          c.rx_clk_oe_n = !s.role; // R02
          c.tx_clk_oe_n = !s.role; // R02
        end
        IF_RMII: begin
          c.ref_in_sel = !s.role; // R03
          c.ref_out_oe_n = !s.role; // R03
        end
        IF_RGMII: begin
          c.rx_clk_oe_n = 1'b0; // R04
          c.tx_clk_oe_n = 1'b1; // R04
          c.speed = force10 ? SPEED_10 : (s.role ? SPEED_1000 : SPEED_100); // R05
        end
        default: c = MAC_CLK_IDLE;
      endcase
    end
    return c;
  endfunction

  // pins cross in through two flops before anything looks at them
  assign raw_pins = {strap_in, energy_in};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      pmcs_sync u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(raw_pins[gi]),
        .q_out(sync_pins[gi])
      );
    end
  endgenerate
  assign energy_sync = sync_pins[NUM_PHY_PORTS-1:0];
  assign strap_sync = sync_pins[SYNC_W-1:NUM_PHY_PORTS];

  // mode field write; the spare code 11 is ignored so one mode always holds
  assign wr_field = mode_wdata_in[PWR_MODE_MSB:PWR_MODE_LSB];
  assign wr_valid = mode_wr_in && (wr_field != MODE_RSVD);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode <= MODE_RESET; // R09
    end else if (wr_valid) begin
      mode <= wr_field; // R10 R11 R12 R24
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= wr_valid && (mode == MODE_SOFT) && (wr_field != MODE_SOFT); // R21
    end
  end

  // strap capture waits for the synchronisers to hold real pin levels
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || soft_reset_out) begin
      settle_cnt <= STRAP_SETTLE; // R21
    end else if (settle_cnt != 2'h0) begin
      settle_cnt <= settle_cnt - 2'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      strap_latched <= '0;
      strap_capture_out <= 1'b0;
    end else begin
      strap_capture_out <= (settle_cnt == 2'h1);
      if (settle_cnt == 2'h1) begin
        strap_latched <= strap_sync; // R02 R03 R05 R21
      end
    end
  end

  // energy from powered-down ports does not wake the device
  pmcs_energy_detect_power_down #(
    .PULSE_INTERVAL_CYC(PULSE_INTERVAL_CYC)
  ) u_energy_detect_power_down (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .active_in(mode == MODE_ENERGY_DETECT_POWER_DOWN),
    .energy_in(|(energy_sync & ~port_pd_in[NUM_PHY_PORTS-1:0])),
    .timeout_in(energy_detect_power_down_timeout_in),
    .low_power_out(ed_low),
    .link_pulse_out(ed_pulse)
  );

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode_out <= MODE_RESET;
      energy_detect_power_down_low_out <= 1'b0;
      link_pulse_out <= 1'b0;
    end else begin
      mode_out <= wr_valid ? wr_field : mode;
      energy_detect_power_down_low_out <= ed_low; // R16
      link_pulse_out <= ed_pulse; // R18
    end
  end

  assign next_gate = gate_for(mode, ed_low);
  assign next_phy_en = {NUM_PHY_PORTS{next_gate.phy_en}} & ~port_pd_in[NUM_PHY_PORTS-1:0];

  // the pll enable gates the multiplied reference that is this block's clock
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      gate_out <= GATE_ALL_ON; // R09
      phy_en_out <= PHY_ALL_ON;
      eee_active_out <= '0;
    end else begin
      gate_out <= next_gate; // R01 R14
      phy_en_out <= next_phy_en; // R22
      eee_active_out <= eee_local_en_in & eee_an_ok_in & next_phy_en; // R23
    end
  end

  generate
    for (gi = 0; gi < NUM_MAC_PORTS; gi++) begin : g_mac_clk
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          mac_clk_out[gi] <= MAC_CLK_IDLE;
        end else begin
          mac_clk_out[gi] <= mac_clk_for(strap_latched[gi], rgmii_force_10_in[gi],
                                         next_gate.mac_en && !port_pd_in[NUM_PHY_PORTS+gi]); // R22
        end
      end
    end
  endgenerate

  // out-of-range source codes fall back to the reference
  assign next_sync_src = (sync_src_in >= SYNC_SRC_FIRST && sync_src_in <= SYNC_SRC_LAST) ? sync_src_in : SYNC_SRC_REF;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mgmt_clk_oe_n_out <= 1'b1;
      sync_src_out <= SYNC_SRC_REF;
      sync_freq_125_out <= 1'b0;
      sync_clk_en_out <= 1'b0;
    end else begin
      mgmt_clk_oe_n_out <= 1'b1; // R06
      sync_src_out <= next_sync_src; // R07
      sync_freq_125_out <= sync_freq_125_in; // R08
      sync_clk_en_out <= !sync_disable_in && (mode != MODE_SOFT); // R08 R20
    end
  end

  power_on_normal_a: assert property (@(posedge mclk_in) // R09
    $past(sys_rst_in) && !sys_rst_in |-> mode_out == MODE_NORMAL && gate_out == GATE_ALL_ON)
    else $error("not in normal mode after reset");

  write_normal_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R10
    mode_wr_in && mode_wdata_in[PWR_MODE_MSB:PWR_MODE_LSB] == MODE_NORMAL |=> mode_out == MODE_NORMAL)
    else $error("mode 00 write did not select normal");

  write_energy_detect_power_down_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R11
    mode_wr_in && mode_wdata_in[PWR_MODE_MSB:PWR_MODE_LSB] == MODE_ENERGY_DETECT_POWER_DOWN |=> mode_out == MODE_ENERGY_DETECT_POWER_DOWN)
    else $error("mode 01 write did not select energy detect");

  mode_exclusive_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R12
    mode_wr_in && mode_wdata_in[PWR_MODE_MSB:PWR_MODE_LSB] == MODE_RSVD |=> $stable(mode_out))
    else $error("reserved mode code changed the mode");

  soft_gating_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R20
    mode == MODE_SOFT |=> gate_out == 6'h01 && phy_en_out == 5'h00 && !sync_clk_en_out)
    else $error("soft power down left a block enabled");

  soft_exit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R21
    $past(mode_out) == MODE_SOFT && mode_out != MODE_SOFT |-> soft_reset_out ##4 strap_capture_out)
    else $error("soft exit without reset and strap resample");

  port_down_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R22
    ##1 (phy_en_out & $past(port_pd_in[NUM_PHY_PORTS-1:0])) == 5'h00)
    else $error("powered down port still enabled");

  eee_gated_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R23
    (eee_active_out & ~phy_en_out) == 5'h00 && (eee_active_out & ~$past(eee_an_ok_in)) == 5'h00)
    else $error("eee active without negotiation or power");

  mgmt_input_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // R06
    mgmt_clk_oe_n_out && gate_out.mgmt_if_en)
    else $error("management clock driven or interface off");
endmodule
`default_nettype wire

// ---- test/pmcs_host_model.sv ----
// host side model issuing power down control writes
`timescale 1ns/100ps
`default_nettype none
module pmcs_host_model
  import pmcs_pkg::*;
(
  // clock
  input wire logic mclk_in,
  // power down control write
  output logic mode_wr_out,
  output logic [CTRL_WIDTH-1:0] mode_wdata_out
);
  logic an_enabled;
  initial begin
    mode_wr_out = 1'b0;
    mode_wdata_out = 8'h00;
    an_enabled = 1'b1;
  end
  // one-cycle strobe; spare bits carry noise because the block must ignore them
  task automatic write_mode(input logic [1:0] field);
    @(posedge mclk_in);
    #1;
    mode_wr_out = an_enabled | (field != MODE_ENERGY_DETECT_POWER_DOWN);
    mode_wdata_out = (8'($urandom) & 8'he7) | {3'h0, field, 3'h0};
    @(posedge mclk_in);
    #1;
    mode_wr_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/power_mode_and_clock_select_tb.sv ----
// self-checking bench for the power mode and clock select block
`timescale 1ns/100ps
`default_nettype none
module power_mode_and_clock_select_tb;
  import pmcs_pkg::*;
  typedef struct {int k; logic [7:0] e; logic [7:0] m;} pmcs_note_type;
  localparam int TQ = 20;
  logic mclk_in, sys_rst_in, mode_wr, sync_freq, sync_dis, mode_soft_rst, strap_cap, energy_detect_power_down_low, link_pulse;
  logic mgmt_oe_n, sync_freq_o, sync_en;
  logic [7:0] mode_wdata, meas;
  logic [15:0] timeout;
  logic [6:0] port_pd;
  logic [4:0] eee_l, eee_a, energy, phy_en, eee_act;
  logic [1:0] force10, mode;
  logic [2:0] sync_src, sync_src_o;
  pmcs_strap_type [1:0] strap;
  pmcs_gate_type gate;
  pmcs_mac_clk_type [1:0] mac_clk;
  pmcs_note_type notes[$];
  pmcs_note_type nt;
  int n_mismatch = 0;
  int num_checks = 0;
  int n, cnt;
  logic [1:0] cur;
  logic [1:0] seq[7] = '{MODE_RSVD, MODE_ENERGY_DETECT_POWER_DOWN, MODE_RSVD, MODE_NORMAL, MODE_SOFT, MODE_RSVD, MODE_NORMAL};
  logic [2:0] st[6] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h4};
  logic [5:0] sm[6] = '{6'h30, 6'h30, 6'h04, 6'h0c, 6'h33, 6'h33};
  logic [5:0] se[6] = '{6'h00, 6'h30, 6'h00, 6'h0c, 6'h12, 6'h11};
  string names[12] = '{"mode", "gate", "phy_en", "energy_detect_power_down_low", "soft_reset", "strap_capture", "mgmt_clk_oe_n",
                       "sync_clk", "eee_active", "mac_clk0", "mac_clk1", "measured"};

  pmcs_host_model u_host (.mclk_in(mclk_in), .mode_wr_out(mode_wr), .mode_wdata_out(mode_wdata));

  pmcs_top #(.PULSE_INTERVAL_CYC(16)) u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .mode_wr_in(mode_wr), .mode_wdata_in(mode_wdata),
    .energy_detect_power_down_timeout_in(timeout), .port_pd_in(port_pd), .eee_local_en_in(eee_l), .eee_an_ok_in(eee_a),
    .energy_in(energy), .strap_in(strap), .rgmii_force_10_in(force10), .sync_src_in(sync_src),
    .sync_freq_125_in(sync_freq), .sync_disable_in(sync_dis), .mode_out(mode), .energy_detect_power_down_low_out(energy_detect_power_down_low),
    .link_pulse_out(link_pulse), .soft_reset_out(mode_soft_rst), .strap_capture_out(strap_cap),
    .gate_out(gate), .phy_en_out(phy_en), .eee_active_out(eee_act), .mac_clk_out(mac_clk),
    .mgmt_clk_oe_n_out(mgmt_oe_n), .sync_src_out(sync_src_o), .sync_freq_125_out(sync_freq_o),
    .sync_clk_en_out(sync_en));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  function automatic logic [7:0] got(input int k);
    case (k)
      0: return {6'h0, mode};
      1: return {2'h0, gate};
      2: return {3'h0, phy_en};
      3: return {7'h0, energy_detect_power_down_low};
      4: return {7'h0, mode_soft_rst};
      5: return {7'h0, strap_cap};
      6: return {7'h0, mgmt_oe_n};
      7: return {3'h0, sync_src_o, sync_freq_o, sync_en};
      8: return {3'h0, eee_act};
      9: return {2'h0, mac_clk[0]};
      10: return {2'h0, mac_clk[1]};
      default: return meas;
    endcase
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(input int k, input logic [7:0] e, input logic [7:0] m = 8'hff);
    notes.push_back('{k, e, m});
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // outputs settle well before the falling edge, so notes are judged there
  always @(negedge mclk_in) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      check(names[nt.k], nt.e & nt.m, got(nt.k) & nt.m);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    sys_rst_in = 1'b1;
    timeout = 16'hffff;
    {port_pd, eee_l, eee_a, energy, force10, sync_src, sync_freq, sync_dis} = '0;
    strap[0] = pmcs_strap_type'(st[0]);
    strap[1] = pmcs_strap_type'(st[3]);
    void'($urandom(23));
    step(7);
    note(0, 8'h00);
    note(1, 8'h3f);
    note(2, 8'h1f);
    note(8, 8'h00);
    step(1);
    sys_rst_in = 1'b0;
    step(6);
    note(9, {2'h0, se[0]}, {2'h0, sm[0]});
    note(10, {2'h0, se[3]}, {2'h0, sm[3]});
    note(6, 8'h01);
    note(7, 8'h01);
    $display("test reset done");
    cur = MODE_NORMAL;
    foreach (seq[i]) begin
      u_host.write_mode(seq[i]);
      if (seq[i] != MODE_RSVD) cur = seq[i];
      note(0, {6'h0, cur});
      step(1);
      note(1, cur == MODE_SOFT ? 8'h01 : 8'h3f);
      note(2, cur == MODE_SOFT ? 8'h00 : 8'h1f);
      note(7, {7'h0, cur != MODE_SOFT}, 8'h01);
    end
    $display("test modes done");
    for (int i = 0; i < 6; i++) begin
      u_host.write_mode(MODE_SOFT);
      strap[0] = pmcs_strap_type'(st[i]);
      strap[1] = pmcs_strap_type'(st[(i + 1) % 6]);
      u_host.write_mode(MODE_NORMAL);
      note(4, 8'h01);
      step(1);
      note(4, 8'h00);
      step(2);
      note(5, 8'h00);
      step(1);
      note(5, 8'h01);
      step(2);
      note(9, {2'h0, se[i]}, {2'h0, sm[i]});
      note(10, {2'h0, se[(i + 1) % 6]}, {2'h0, sm[(i + 1) % 6]});
    end
    force10[0] = 1'b1;
    step(3);
    note(9, 8'h00, 8'h03);
    force10[0] = 1'b0;
    $display("test straps done");
    repeat (4) begin
      port_pd = 7'($urandom);
      eee_l = 5'($urandom);
      eee_a = 5'($urandom);
      step(3);
      note(2, {3'h0, ~port_pd[4:0]});
      note(8, {3'h0, eee_l & eee_a}, {3'h0, ~port_pd[4:0]});
      note(9, port_pd[5] ? {2'h0, MAC_CLK_IDLE} : {2'h0, se[5]}, port_pd[5] ? 8'hff : {2'h0, sm[5]});
      note(10, port_pd[6] ? {2'h0, MAC_CLK_IDLE} : {2'h0, se[0]}, port_pd[6] ? 8'hff : {2'h0, sm[0]});
    end
    port_pd = '0;
    for (int i = 0; i < 8; i++) begin
      sync_src = 3'(i);
      sync_freq = 1'($urandom);
      sync_dis = 1'($urandom);
      step(3);
      note(7, {3'h0, (i > 5) ? 3'h0 : 3'(i), sync_freq, ~sync_dis});
    end
    sync_dis = 1'b0;
    $display("test sync clock done");
    timeout = 16'(TQ);
    energy = 5'h01;
    u_host.write_mode(MODE_ENERGY_DETECT_POWER_DOWN);
    step(5);
    note(3, 8'h00);
    energy = 5'h00;
    n = 0;
    while (energy_detect_power_down_low !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    meas = {7'h0, n >= TQ + 3 && n <= TQ + 8};
    note(11, 8'h01);
    note(1, 8'h09);
    cnt = 0;
    repeat (64) begin
      step(1);
      cnt += int'(link_pulse === 1'b1);
    end
    meas = {7'h0, cnt == 4};
    note(11, 8'h01);
    energy = 5'h01;
    step(5);
    energy = 5'h00;
    step(10);
    note(3, 8'h01);
    port_pd = 7'h02;
    energy = 5'h02;
    step(20);
    note(3, 8'h01);
    energy = 5'h01;
    port_pd = '0;
    n = 0;
    while (energy_detect_power_down_low !== 1'b0 && n < 50) begin
      step(1);
      n++;
    end
    meas = {7'h0, n >= 7 && n <= 11};
    note(11, 8'h01);
    note(1, 8'h3f);
    u_host.write_mode(MODE_NORMAL);
    energy = 5'h00;
    $display("test energy detect done");
    step(2);
    give_verdict();
  end
endmodule
`default_nettype wire
